// [logic/dcc_corrector.sv]
// Purpose: Gain and zero correction of one 12-bit code
// Assumes: Codes already in offset-binary form
// Notes: Purely combinational, result clamped to 12 bits
`timescale 1ns/1ps
`default_nettype none
module dcc_corrector (
  input wire logic [11:0] code_in,
  input wire logic [11:0] user_gain,
  input wire logic [11:0] user_zero,
  output logic [11:0] code_out
);
  import dcc_pkg::*;
  logic [12:0] gain_ext;
  logic [24:0] prod;
  logic signed [14:0] sum;
  // Multiply by gain plus half scale, divide by full scale, add signed zero
  always_comb begin
    gain_ext = {1'b0, user_gain} + {1'b0, DCC_GAIN_RST};
    prod = {13'h0, code_in} * {12'h000, gain_ext};
    sum = $signed({2'b00, prod[24:12]}) + $signed({{3{user_zero[11]}}, user_zero});
    if (sum < 0) begin
      code_out = 12'h000;
    end else if (sum > 15'sh0FFF) begin
      code_out = 12'hFFF;
    end else begin
      code_out = sum[11:0];
    end
  end
endmodule : dcc_corrector
`default_nettype wire

// [logic/dcc_fmt.sv]
// Purpose: Convert between the strap-selected format and offset binary
// Assumes: Twos complement differs from straight binary by the top bit
// Notes: Same function serves both directions
`timescale 1ns/1ps
`default_nettype none
module dcc_fmt (
  input wire logic twos_sel,
  input wire logic [11:0] code_in,
  output logic [11:0] code_out
);
  // Invert MSB when the strap selects twos complement
  assign code_out = {code_in[11] ^ twos_sel, code_in[10:0]};
endmodule : dcc_fmt
`default_nettype wire

// [logic/dcc_path.sv]
// Purpose: Eight-channel code path with user gain and zero correction
// Assumes: Single clock, strap from a pin, host over AXI4-Lite
// Notes: Corrected codes computed one channel every two cycles on demand
// Summary of operation
// - With correction off, each channel output equals its input code.
// - With correction on, output is input times (gain plus 2048) over 4096 plus zero.
// - Gain is always unsigned and zero always signed, whatever the strap.
// - Reads return registers exactly as written, no conversion.
// - The strap selects straight binary when low and twos complement when high.
// - Straight binary puts zero at 800h, top at FFFh, bottom at 000h.
// - Twos complement puts zero at 000h, top at 7FFh, bottom at 800h.
// - Reset loads gains with 2048, zeros with zero and inputs with 000h.
// - Group offsets default to the trimmed value for gain six or four.
// - A gain-select change reloads both group offsets with the new default.
// - Two 12-bit group offset registers, one per four channels.
// - One gain-select bit picks gain six or four and the offset default set.
// - With correction off, gain and zero writes only store and read back.
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dcc_path #(
  parameter logic [11:0] OFS6_TRIM_A = dcc_pkg::DCC_OFS6_NOM,
  parameter logic [11:0] OFS6_TRIM_B = dcc_pkg::DCC_OFS6_NOM,
  parameter logic [11:0] OFS4_TRIM_A = dcc_pkg::DCC_OFS4_NOM,
  parameter logic [11:0] OFS4_TRIM_B = dcc_pkg::DCC_OFS4_NOM
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic format_select_strap,
  input wire logic [dcc_pkg::DCC_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dcc_pkg::DCC_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [95:0] chan_code,
  output logic gain_six,
  output logic [11:0] group_offset_code_a,
  output logic [11:0] group_offset_code_b
);
  import dcc_pkg::*;

  typedef struct packed {
    logic strap_m;
    logic strap_s;
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic correction_enable;
    logic gsel;
    logic [11:0] ofs_a;
    logic [11:0] ofs_b;
    logic [7:0][11:0] din;
    logic [7:0][11:0] gain;
    logic [7:0][11:0] zero;
    logic [7:0][11:0] dout;
    logic [7:0] pend;
    dcc_state_t st;
    logic [2:0] cur;
  } dcc_regs_t;

  dcc_regs_t s_r;
  dcc_regs_t s_nxt;
  logic [11:0] cor_in;
  logic [11:0] cor_out;
  logic [11:0] res_fmt;
  logic [11:0] def_a;
  logic [11:0] def_b;
  logic [2:0] pick;
  logic pick_any;
  logic wr_go;
  logic [11:0] wval;

  // Convert selected input to offset binary for the arithmetic
  dcc_fmt u_fmt_in (
    .twos_sel(s_r.strap_s),
    .code_in(s_r.din[s_r.cur]),
    .code_out(cor_in)
  );

  dcc_corrector u_cor (
    .code_in(cor_in),
    .user_gain(s_r.gain[s_r.cur]),
    .user_zero(s_r.zero[s_r.cur]),
    .code_out(cor_out)
  );

  // Back to the strap format so the output matches the input encoding
  dcc_fmt u_fmt_out (
    .twos_sel(s_r.strap_s),
    .code_in(cor_out),
    .code_out(res_fmt)
  );

  // Offset defaults for the gain being switched to, in the strap format
  // One select bit, so a change always lands on the other gain
  always_comb begin
    def_a = s_r.gsel ? OFS4_TRIM_A : OFS6_TRIM_A;
    def_b = s_r.gsel ? OFS4_TRIM_B : OFS6_TRIM_B;
    def_a[11] = def_a[11] ^ s_r.strap_s;
    def_b[11] = def_b[11] ^ s_r.strap_s;
  end

  // Lowest pending channel goes first
  always_comb begin
    pick = 3'h0;
    pick_any = 1'b0;
    for (int i = DCC_NCH - 1; i >= 0; i--) begin
      if (s_r.pend[i]) begin
        pick = 3'(i);
        pick_any = 1'b1;
      end
    end
  end

  assign wr_go = s_r.aw_hold && s_r.w_hold && !s_r.bvalid;
  assign wval = s_r.w_data[11:0];

  // Bus handshake, register writes, correction sequencing
  always_comb begin
    s_nxt = s_r;
    s_nxt.strap_m = format_select_strap;
    s_nxt.strap_s = s_r.strap_m;
    if (s_axi_awvalid && !s_r.aw_hold) begin
      s_nxt.aw_hold = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.w_hold) begin
      s_nxt.w_hold = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (wr_go) begin
      s_nxt.aw_hold = 1'b0;
      s_nxt.w_hold = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = DCC_RESP_OKAY;
      // Partial strobes on the low half are ignored as a whole
      if (s_r.w_strb[1:0] == 2'b11) begin
        if (s_r.aw_addr[7:5] == DCC_OFF_INPUT[7:5]) begin
          s_nxt.din[s_r.aw_addr[4:2]] = wval;
          s_nxt.pend[s_r.aw_addr[4:2]] = 1'b1;
        end else if (s_r.aw_addr[7:5] == DCC_OFF_GAIN[7:5]) begin
          s_nxt.gain[s_r.aw_addr[4:2]] = wval;
          s_nxt.pend[s_r.aw_addr[4:2]] = s_r.correction_enable;
        end else if (s_r.aw_addr[7:5] == DCC_OFF_ZERO[7:5]) begin
          s_nxt.zero[s_r.aw_addr[4:2]] = wval;
          s_nxt.pend[s_r.aw_addr[4:2]] = s_r.correction_enable;
        end else if (s_r.aw_addr == DCC_OFF_CFG) begin
          s_nxt.correction_enable = s_r.w_data[DCC_CFG_CE_BIT];
          s_nxt.gsel = s_r.w_data[DCC_CFG_GAIN_BIT];
        end else if (s_r.aw_addr == DCC_OFF_OFSA) begin
          s_nxt.ofs_a = wval;
        end else if (s_r.aw_addr == DCC_OFF_OFSB) begin
          s_nxt.ofs_b = wval;
        end else if (s_r.aw_addr[7:5] != DCC_OFF_OUT[7:5] && s_r.aw_addr != DCC_OFF_STAT) begin
          s_nxt.bresp = DCC_RESP_SLVERR;
        end
      end
      // Enabling correction recomputes every channel
      if (s_r.aw_addr == DCC_OFF_CFG && s_r.w_data[DCC_CFG_CE_BIT] && !s_r.correction_enable) begin
        s_nxt.pend = 8'hFF;
      end
    end
    // Gain change reloads both offsets; a same-cycle offset write loses
    // Defaults follow the strap as it stands now, not as it stood at reset
    if (s_r.gsel != s_nxt.gsel) begin
      s_nxt.ofs_a = def_a;
      s_nxt.ofs_b = def_b;
    end
    // Correction off: every output tracks its input directly
    if (!s_r.correction_enable) begin
      s_nxt.dout = s_r.din;
      s_nxt.st = DCC_ST_IDLE;
      s_nxt.pend = (wr_go && s_r.aw_addr == DCC_OFF_CFG) ? s_nxt.pend : 8'h00;
    end else begin
      case (s_r.st)
        DCC_ST_IDLE: begin
          if (pick_any) begin
            s_nxt.cur = pick;
            s_nxt.st = DCC_ST_CALC;
          end
        end
        DCC_ST_CALC: begin
          s_nxt.dout[s_r.cur] = res_fmt;
          s_nxt.st = DCC_ST_IDLE;
          // A rewrite during this cycle keeps its own pending flag
          if (!(wr_go && s_r.aw_addr[4:2] == s_r.cur && s_nxt.pend[s_r.cur]
                && s_r.aw_addr[7:5] != DCC_OFF_OUT[7:5])) begin
            s_nxt.pend[s_r.cur] = 1'b0;
          end
        end
        default: s_nxt.st = DCC_ST_IDLE;
      endcase
    end
    // Read channel: one word at a time
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = DCC_RESP_OKAY;
      s_nxt.rdata = 32'h0000_0000;
      if (s_axi_araddr[7:5] == DCC_OFF_INPUT[7:5]) begin
        s_nxt.rdata[11:0] = s_r.din[s_axi_araddr[4:2]];
      end else if (s_axi_araddr[7:5] == DCC_OFF_GAIN[7:5]) begin
        s_nxt.rdata[11:0] = s_r.gain[s_axi_araddr[4:2]];
      end else if (s_axi_araddr[7:5] == DCC_OFF_ZERO[7:5]) begin
        s_nxt.rdata[11:0] = s_r.zero[s_axi_araddr[4:2]];
      end else if (s_axi_araddr[7:5] == DCC_OFF_OUT[7:5]) begin
        s_nxt.rdata[11:0] = s_r.dout[s_axi_araddr[4:2]];
      end else if (s_axi_araddr == DCC_OFF_CFG) begin
        s_nxt.rdata[DCC_CFG_CE_BIT] = s_r.correction_enable;
        s_nxt.rdata[DCC_CFG_GAIN_BIT] = s_r.gsel;
      end else if (s_axi_araddr == DCC_OFF_OFSA) begin
        s_nxt.rdata[11:0] = s_r.ofs_a;
      end else if (s_axi_araddr == DCC_OFF_OFSB) begin
        s_nxt.rdata[11:0] = s_r.ofs_b;
      end else if (s_axi_araddr == DCC_OFF_STAT) begin
        s_nxt.rdata[7:0] = s_r.pend;
        s_nxt.rdata[8] = s_r.strap_s;
      end else begin
        s_nxt.rresp = DCC_RESP_SLVERR;
      end
    end
  end

  // State register; reset loads the gain-four trim defaults as they are, whatever the strap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.correction_enable <= DCC_CE_RST;
      s_r.gsel <= DCC_GSEL_RST;
      s_r.ofs_a <= OFS4_TRIM_A;
      s_r.ofs_b <= OFS4_TRIM_B;
      s_r.st <= DCC_ST_IDLE;
      for (int i = 0; i < DCC_NCH; i++) begin
        s_r.din[i] <= DCC_INPUT_RST;
        s_r.gain[i] <= DCC_GAIN_RST;
        s_r.zero[i] <= DCC_ZERO_RST;
        s_r.dout[i] <= DCC_INPUT_RST;
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign s_axi_awready = !s_r.aw_hold;
  assign s_axi_wready = !s_r.w_hold;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign chan_code = s_r.dout;
  assign gain_six = s_r.gsel;
  assign group_offset_code_a = s_r.ofs_a;
  assign group_offset_code_b = s_r.ofs_b;
endmodule : dcc_path
`default_nettype wire

// [pkg/dcc_pkg.sv]
// Purpose: Constants and register map for the DAC code calibration path
// Assumes: AXI4-Lite slave with 32-bit data, 12-bit codes
// Notes: Offsets are byte addresses, one aligned word per register
package dcc_pkg;
  localparam int DCC_NCH = 8;
  localparam int DCC_CW = 12;
  localparam int DCC_AW = 8;
  // Register map
  localparam logic [7:0] DCC_OFF_CFG = 8'h00;
  localparam logic [7:0] DCC_OFF_OFSA = 8'h04;
  localparam logic [7:0] DCC_OFF_OFSB = 8'h08;
  localparam logic [7:0] DCC_OFF_STAT = 8'h0C;
  localparam logic [7:0] DCC_OFF_INPUT = 8'h20;
  localparam logic [7:0] DCC_OFF_GAIN = 8'h40;
  localparam logic [7:0] DCC_OFF_ZERO = 8'h60;
  localparam logic [7:0] DCC_OFF_OUT = 8'h80;
  // Config fields
  localparam int DCC_CFG_CE_BIT = 0;
  localparam int DCC_CFG_GAIN_BIT = 1;
  // Reset values
  localparam logic [11:0] DCC_GAIN_RST = 12'h800;
  localparam logic [11:0] DCC_ZERO_RST = 12'h000;
  localparam logic [11:0] DCC_INPUT_RST = 12'h000;
  localparam logic [11:0] DCC_MID_OFS = 12'h800;
  localparam logic [11:0] DCC_OFS6_NOM = 12'h99A;
  localparam logic [11:0] DCC_OFS4_NOM = 12'hAAB;
  localparam logic DCC_CE_RST = 1'b0;
  localparam logic DCC_GSEL_RST = 1'b0;
  // AXI responses
  localparam logic [1:0] DCC_RESP_OKAY = 2'h0;
  localparam logic [1:0] DCC_RESP_SLVERR = 2'h2;
  // Channel update states
  typedef enum logic [1:0] {
    DCC_ST_IDLE = 2'b00,
    DCC_ST_CALC = 2'b01
  } dcc_state_t;
endpackage : dcc_pkg

// [tb/dcc_host.sv]
// Purpose: Host processor driving the register bus
// Assumes: One write and one read at a time
// Notes: Waits have no bound here, the bench timeout ends a hang
`timescale 1ns/1ps
`default_nettype none
module dcc_host (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic [2:0] s_axi_awprot,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic [2:0] s_axi_arprot,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // Idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end
  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [11:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {20'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
endmodule : dcc_host
`default_nettype wire

// [tb/dcc_path_sva.sv]
// Purpose: Port checks for the code calibration path
// Assumes: One clock, synchronous active-low reset
// Notes: Reloaded offsets compared on low 11 bits, the strap flips the top one
`timescale 1ns/1ps
`default_nettype none
module dcc_path_sva #(
  parameter logic [11:0] OFS6_TRIM_A = dcc_pkg::DCC_OFS6_NOM,
  parameter logic [11:0] OFS6_TRIM_B = dcc_pkg::DCC_OFS6_NOM,
  parameter logic [11:0] OFS4_TRIM_A = dcc_pkg::DCC_OFS4_NOM,
  parameter logic [11:0] OFS4_TRIM_B = dcc_pkg::DCC_OFS4_NOM
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [95:0] chan_code,
  input wire logic gain_six,
  input wire logic [11:0] group_offset_code_a,
  input wire logic [11:0] group_offset_code_b
);
  import dcc_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // State seen right after reset leaves
  rst_vals_a: assert property ($rose(aresetn) |-> chan_code == 96'h0 && !gain_six
    && group_offset_code_a == OFS4_TRIM_A && group_offset_code_b == OFS4_TRIM_B)
    else $error("reset state wrong");
  // Gain change reloads both group offsets
  six_ofs_a: assert property ($rose(gain_six) |->
    group_offset_code_a[10:0] == OFS6_TRIM_A[10:0] && group_offset_code_b[10:0] == OFS6_TRIM_B[10:0])
    else $error("gain six offsets wrong");
  four_ofs_a: assert property ($fell(gain_six) |->
    group_offset_code_a[10:0] == OFS4_TRIM_A[10:0] && group_offset_code_b[10:0] == OFS4_TRIM_B[10:0])
    else $error("gain four offsets wrong");
  // Bus answers and their spacing
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  err_data_a: assert property (s_axi_rvalid && s_axi_rresp == DCC_RESP_SLVERR |-> s_axi_rdata == 0)
    else $error("error read carries data");
  // Main scenarios
  cover property ($rose(gain_six));
  cover property (s_axi_rvalid && s_axi_rresp == DCC_RESP_SLVERR);
  cover property ($changed(chan_code));
endmodule : dcc_path_sva
bind dcc_path dcc_path_sva #(.OFS6_TRIM_A(OFS6_TRIM_A), .OFS6_TRIM_B(OFS6_TRIM_B),
  .OFS4_TRIM_A(OFS4_TRIM_A), .OFS4_TRIM_B(OFS4_TRIM_B)) u_dcc_path_sva (.*);
`default_nettype wire

// [tb/tb_dcc_path.sv]
// Purpose: Self-checking bench for the code calibration path
// Assumes: Correction needs at most 16 cycles for all channels
// Notes: Expected codes worked out by hand from the transfer rule
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module tb_dcc_path;
  import dcc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic format_select_strap = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [95:0] chan_code;
  logic gain_six;
  logic [11:0] group_offset_code_a, group_offset_code_b;
  int checks = 0;
  int bad_count = 0;
  int cyc = 0;
  dcc_path u_dcc_path (.*);
  dcc_host u_dcc_host (.*);
  // 50 MHz clock
  always #10 aclk = ~aclk;
  task results;
    if (bad_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  // Hang guard, far beyond the expected run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      results();
    end
  end
  function automatic logic [7:0] ad(logic [7:0] b, int n);
    return b + 8'(4 * n);
  endfunction : ad
  function automatic logic [11:0] ch(int n);
    return chan_code[12 * n +: 12];
  endfunction : ch
  task automatic wt(int n);
    repeat (n) @(posedge aclk);
  endtask : wt
  task automatic w(input logic [7:0] a, input logic [11:0] d);
    logic [1:0] r;
    u_dcc_host.wr(a, d, 4'hF, r);
  endtask : w
  task automatic rchk(input logic [7:0] a, input logic [11:0] e);
    logic [31:0] d;
    logic [1:0] r;
    u_dcc_host.rd(a, d, r);
    `CHK(d, {20'h0, e})
  endtask : rchk
  task automatic setch(int n, logic [11:0] i, logic [11:0] g, logic [11:0] z);
    w(ad(DCC_OFF_INPUT, n), i);
    w(ad(DCC_OFF_GAIN, n), g);
    w(ad(DCC_OFF_ZERO, n), z);
  endtask : setch
  task automatic rst;
    aresetn <= 1'b0;
    wt(5);
    aresetn <= 1'b1;
  endtask : rst
  task automatic t_reset;
    rchk(ad(DCC_OFF_GAIN, 7), 12'h800);
    rchk(ad(DCC_OFF_ZERO, 0), 12'h000);
    rchk(ad(DCC_OFF_INPUT, 3), 12'h000);
    rchk(DCC_OFF_OFSA, 12'hAAB);
    rchk(DCC_OFF_OFSB, 12'hAAB);
    `CHK(chan_code, 96'h0)
    `CHK(gain_six, 1'b0)
  endtask : t_reset
  // Correction off: codes pass, gain writes only store
  task automatic t_pass;
    w(ad(DCC_OFF_INPUT, 5), 12'h123);
    wt(2);
    `CHK(ch(5), 12'h123)
    w(ad(DCC_OFF_GAIN, 5), 12'h456);
    wt(4);
    `CHK(ch(5), 12'h123)
    rchk(ad(DCC_OFF_GAIN, 5), 12'h456);
  endtask : t_pass
  // Enabling recomputes all, incl. both saturation ends
  task automatic t_corr;
    setch(0, 12'hFFF, 12'hFFF, 12'h000);
    setch(1, 12'h800, 12'h800, 12'hFFF);
    setch(2, 12'h010, 12'h800, 12'h800);
    w(DCC_OFF_CFG, 12'h001);
    wt(20);
    `CHK(ch(0), 12'hFFF)
    `CHK(ch(1), 12'h7FF)
    `CHK(ch(2), 12'h000)
    `CHK(ch(5), 12'h0E0)
    w(ad(DCC_OFF_ZERO, 1), 12'h001);
    wt(20);
    `CHK(ch(1), 12'h801)
    rchk(ad(DCC_OFF_ZERO, 1), 12'h001);
  endtask : t_corr
  // Twos complement codes, then gain select swaps offsets
  task automatic t_twos;
    format_select_strap <= 1'b1;
    wt(4);
    setch(3, 12'h000, 12'h800, 12'h001);
    setch(4, 12'h7FF, 12'hFFF, 12'h000);
    wt(20);
    `CHK(ch(3), 12'h001)
    `CHK(ch(4), 12'h7FF)
    rchk(ad(DCC_OFF_INPUT, 4), 12'h7FF);
    w(DCC_OFF_CFG, 12'h003);
    wt(1);
    `CHK(gain_six, 1'b1)
    `CHK(group_offset_code_a, 12'h19A)
    `CHK(group_offset_code_b, 12'h19A)
    w(DCC_OFF_OFSA, 12'h123);
    w(DCC_OFF_OFSB, 12'h456);
    rchk(DCC_OFF_OFSA, 12'h123);
    rchk(DCC_OFF_OFSB, 12'h456);
    w(DCC_OFF_CFG, 12'h001);
    wt(1);
    `CHK(group_offset_code_a, 12'h2AB)
    `CHK(group_offset_code_b, 12'h2AB)
  endtask : t_twos
  // Unmapped place answers with an error; a partial strobe stores nothing
  task automatic t_err;
    logic [31:0] d;
    logic [1:0] r;
    u_dcc_host.rd(8'hFC, d, r);
    `CHK(r, DCC_RESP_SLVERR)
    `CHK(d, 32'h0)
    u_dcc_host.wr(8'hFC, 12'h5A5, 4'hF, r);
    `CHK(r, DCC_RESP_SLVERR)
    u_dcc_host.wr(ad(DCC_OFF_GAIN, 5), 12'h777, 4'h1, r);
    `CHK(r, DCC_RESP_OKAY)
    rchk(ad(DCC_OFF_GAIN, 5), 12'h456);
    rchk(DCC_OFF_STAT, 12'h100);
    rchk(ad(DCC_OFF_OUT, 3), 12'h001);
  endtask : t_err
  // Main sequence, with a second reset and reset check after the last test
  initial begin
    rst();
    t_reset();
    t_pass();
    t_corr();
    t_twos();
    t_err();
    rst();
    t_reset();
    results();
  end
endmodule : tb_dcc_path
`default_nettype wire
